//--- logic/ftm_fan_monitor.sv
// Purpose: Two-fan tach period monitor with limits and interrupt
// Assumes: Tach inputs asynchronous; plain register port, read data next cycle
// Notes:   Fans measured in turn; analog use of pins leaves a fan skipped
`timescale 1ns/10ps
module ftm_fan_monitor
    import ftm_pkg::*;
#(
    parameter int unsigned DIV = TBASE_DIV
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // Tach inputs
    input  wire logic        tach_input_first,
    input  wire logic        tach_input_second,
    // Register port
    input  wire ftm_bus_req_t bus,
    output logic [31:0]      rdata,
    // Sequence start and interrupt outputs
    output logic             analog_start,
    output logic             irq,
    output logic             irq_oe
);
    // Tick compare is 16 bits wide and needs at least two cycles per tick
    if (DIV < 2 || DIV > 65536) begin : g_bad_div
        $error("DIV out of range for the time base divider");
    end

    typedef enum logic [1:0] {SQ_IDLE, SQ_TACH_INPUT_FIRST, SQ_TACH_INPUT_SECOND} ftm_seq_t;

    logic [7:0]  config_r, next_config;
    logic [7:0]  chmode, next_chmode;
    logic [7:0]  viddiv, next_viddiv;
    logic [7:0]  speed1, next_speed1;
    logic [7:0]  speed2, next_speed2;
    logic [7:0]  limit1, next_limit1;
    logic [7:0]  limit2, next_limit2;
    logic [1:0]  status, next_status;
    logic [1:0]  mask, next_mask;
    logic [31:0] next_rdata;
    logic [1:0]  sync_a, sync_b, tach_q;
    logic [1:0]  tach_rise;
    logic [15:0] tb_cnt;
    logic        tick;
    ftm_seq_t    seq, next_seq;
    logic        run, run_q;
    logic        pc_start;
    logic        pc_done;
    logic [7:0]  pc_count;
    logic        sel_rise;
    logic [1:0]  sel_div;
    logic [1:0]  fan_en;

    // Two-flop sync per tach, edge taken from second stage only
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            // Pull-up level, so leaving reset shows no false rising edge
            sync_a <= '1;
            sync_b <= '1;
            tach_q <= '1;
        end else begin
            sync_a <= {tach_input_second, tach_input_first};
            sync_b <= sync_a;
            tach_q <= sync_b;
        end
    end

    assign tach_rise = sync_b & ~tach_q;

    // Time base divider; integer divide leaves the tick slightly fast
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tb_cnt <= '0;
        end else if (tb_cnt == 16'(DIV - 1)) begin
            tb_cnt <= '0;
        end else begin
            tb_cnt <= tb_cnt + 16'h0001;
        end
    end

    assign tick   = (tb_cnt == 16'(DIV - 1));
    assign fan_en = ~chmode[1:0];
    assign run    = config_r[CFG_START] && !config_r[CFG_INT_CLR];
    assign analog_start = run && !run_q;

    // Sequencer: one fan at a time
    always_comb begin
        next_seq = seq;
        pc_start = 1'b0;
        case (seq)
            SQ_IDLE: begin
                if (run) begin
                    next_seq = fan_en[0] ? SQ_TACH_INPUT_FIRST : SQ_TACH_INPUT_SECOND;
                    pc_start = fan_en[0] || fan_en[1];
                    if (!fan_en[0] && !fan_en[1]) begin
                        next_seq = SQ_IDLE;
                    end
                end
            end
            SQ_TACH_INPUT_FIRST: begin
                if (!run) begin
                    next_seq = SQ_IDLE;
                end else if (pc_done) begin
                    next_seq = fan_en[1] ? SQ_TACH_INPUT_SECOND : SQ_TACH_INPUT_FIRST;
                    pc_start = 1'b1;
                end
            end
            SQ_TACH_INPUT_SECOND: begin
                if (!run) begin
                    next_seq = SQ_IDLE;
                end else if (pc_done) begin
                    next_seq = fan_en[0] ? SQ_TACH_INPUT_FIRST : SQ_TACH_INPUT_SECOND;
                    pc_start = 1'b1;
                end
            end
            default: next_seq = SQ_IDLE;
        endcase
    end

    assign sel_rise = (seq == SQ_TACH_INPUT_SECOND) ? tach_rise[1] : tach_rise[0];
    assign sel_div  = (seq == SQ_TACH_INPUT_SECOND) ? viddiv[DIV2_LSB +: 2]
                                       : viddiv[DIV1_LSB +: 2];

    ftm_period_counter u_cnt (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .start     (pc_start),
        .tach_rise (sel_rise),
        .tick      (tick),
        .div_sel   (sel_div),
        .done      (pc_done),
        .count     (pc_count)
    );

    // Register file
    always_comb begin
        next_config = config_r;
        next_chmode = chmode;
        next_viddiv = viddiv;
        next_speed1 = speed1;
        next_speed2 = speed2;
        next_limit1 = limit1;
        next_limit2 = limit2;
        next_status = status;
        next_mask   = mask;
        next_rdata  = '0;
        if (bus.wr) begin
            case (bus.addr)
                OFS_CONFIG: next_config = bus.wdata[7:0];
                OFS_CHMODE: next_chmode = bus.wdata[7:0];
                OFS_VIDDIV: next_viddiv = bus.wdata[7:0];
                OFS_LIMIT1: next_limit1 = bus.wdata[7:0];
                OFS_LIMIT2: next_limit2 = bus.wdata[7:0];
                OFS_STATUS: next_status = status & ~bus.wdata[1:0];
                OFS_MASK:   next_mask   = bus.wdata[1:0];
                default:    next_config = config_r;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                OFS_CONFIG: next_rdata = {24'h0, config_r};
                OFS_CHMODE: next_rdata = {24'h0, chmode};
                OFS_VIDDIV: next_rdata = {24'h0, viddiv};
                OFS_SPEED1: next_rdata = {24'h0, speed1};
                OFS_SPEED2: next_rdata = {24'h0, speed2};
                OFS_LIMIT1: next_rdata = {24'h0, limit1};
                OFS_LIMIT2: next_rdata = {24'h0, limit2};
                OFS_STATUS: next_rdata = {30'h0, status};
                OFS_MASK:   next_rdata = {30'h0, mask};
                default:    next_rdata = '0;
            endcase
            if (bus.addr == OFS_STATUS) begin
                next_status = '0;
            end
        end
        // Hardware update after clears, so a fresh result is never lost
        if (pc_done && seq == SQ_TACH_INPUT_FIRST) begin
            next_speed1 = pc_count;
            next_status[0] = (pc_count > limit1);
        end
        if (pc_done && seq == SQ_TACH_INPUT_SECOND) begin
            next_speed2 = pc_count;
            next_status[1] = (pc_count > limit2);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            config_r <= CONFIG_RST;
            chmode   <= CHMODE_RST;
            viddiv   <= VIDDIV_RST;
            speed1   <= '0;
            speed2   <= '0;
            limit1   <= LIMIT_RST;
            limit2   <= LIMIT_RST;
            status   <= '0;
            mask     <= MASK_RST;
            rdata    <= '0;
            seq      <= SQ_IDLE;
            run_q    <= 1'b0;
            irq      <= 1'b0;
            irq_oe   <= 1'b0;
        end else begin
            config_r <= next_config;
            chmode   <= next_chmode;
            viddiv   <= next_viddiv;
            speed1   <= next_speed1;
            speed2   <= next_speed2;
            limit1   <= next_limit1;
            limit2   <= next_limit2;
            status   <= next_status;
            mask     <= next_mask;
            rdata    <= next_rdata;
            seq      <= next_seq;
            run_q    <= run;
            irq      <= |(status & ~mask) && !config_r[CFG_INT_CLR];
            irq_oe   <= config_r[CFG_INT_EN];
        end
    end
endmodule

//--- logic/ftm_period_counter.sv
// Purpose: One saturating period counter gated over two tach periods
// Assumes: tach_rise is a one-cycle pulse in ref_clk domain
// Notes:   Counts prescaled time-base ticks
`timescale 1ns/10ps
module ftm_period_counter
    import ftm_pkg::*;
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    // Control
    input  wire logic             start,
    input  wire logic             tach_rise,
    input  wire logic             tick,
    input  wire logic [1:0]       div_sel,
    // Result
    output logic                  done,
    output logic [CNT_W-1:0]      count
);
    typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN} ftm_pc_state_t;

    ftm_pc_state_t    state, next_state;
    logic [CNT_W-1:0] next_count;
    logic [2:0]       pre, next_pre;
    logic             edges, next_edges;
    logic             next_done;
    logic [2:0]       pre_top;

    always_comb begin
        pre_top = 3'((4'h1 << div_sel) - 4'h1);
    end

    always_comb begin
        next_state = state;
        next_count = count;
        next_pre   = pre;
        next_edges = edges;
        next_done  = 1'b0;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_ARM;
                end
            end
            ST_ARM: begin
                if (tach_rise) begin
                    next_state = ST_RUN;
                    next_count = '0;
                    next_pre   = '0;
                    next_edges = 1'b0;
                end
            end
            ST_RUN: begin
                if (tick) begin
                    if (pre >= pre_top) begin
                        next_pre = '0;
                        if (count != CNT_FULL) begin
                            next_count = count + 8'h01;
                        end
                    end else begin
                        next_pre = pre + 3'h1;
                    end
                end
                if (tach_rise) begin
                    next_edges = 1'b1;
                end
                if ((tach_rise && edges) || count == CNT_FULL) begin
                    next_state = ST_IDLE;
                    next_done  = 1'b1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            count <= '0;
            pre   <= '0;
            edges <= 1'b0;
            done  <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            pre   <= next_pre;
            edges <= next_edges;
            done  <= next_done;
        end
    end
endmodule

//--- logic/ftm_pkg.sv
// Purpose: Shared constants and types for the fan tach period monitor
// Assumes: 100 MHz ref_clk, 32-bit plain register port
// Notes:   Offsets are byte addresses of word registers
package ftm_pkg;
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned TBASE_HZ     = 22_500;
    localparam int unsigned TBASE_DIV    = CLK_HZ / TBASE_HZ;
    localparam int unsigned CNT_W        = 8;
    localparam logic [7:0]  CNT_FULL     = 8'hff;

    // Register offsets
    localparam logic [7:0] OFS_CONFIG    = 8'h00;
    localparam logic [7:0] OFS_CHMODE    = 8'h04;
    localparam logic [7:0] OFS_VIDDIV    = 8'h08;
    localparam logic [7:0] OFS_SPEED1    = 8'h0c;
    localparam logic [7:0] OFS_SPEED2    = 8'h10;
    localparam logic [7:0] OFS_LIMIT1    = 8'h14;
    localparam logic [7:0] OFS_LIMIT2    = 8'h18;
    localparam logic [7:0] OFS_STATUS    = 8'h1c;
    localparam logic [7:0] OFS_MASK      = 8'h20;

    // Configuration bit positions
    localparam int unsigned CFG_START    = 0;
    localparam int unsigned CFG_INT_EN   = 1;
    localparam int unsigned CFG_INT_CLR  = 3;

    // Fan divisor fields in the combined register
    localparam int unsigned DIV1_LSB     = 4;
    localparam int unsigned DIV2_LSB     = 6;

    // Reset values
    localparam logic [7:0] CONFIG_RST    = 8'h00;
    localparam logic [7:0] CHMODE_RST    = 8'h00;
    localparam logic [7:0] VIDDIV_RST    = 8'h50;
    localparam logic [7:0] LIMIT_RST     = 8'hff;
    localparam logic [1:0] MASK_RST      = 2'h0;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ftm_bus_req_t;
endpackage

//--- sim/ftm_checker.sv
// Purpose: Port assertions for the fan tach period monitor
// Assumes: One clock, async active-low reset
// Notes:   Bound onto every ftm_fan_monitor instance
`timescale 1ns/10ps
module ftm_checker
    import ftm_pkg::*;
(
    // Clock and reset
    input wire logic         ref_clk,
    input wire logic         nrst,
    // Watched ports
    input wire logic         tach_input_first,
    input wire logic         tach_input_second,
    input wire ftm_bus_req_t bus,
    input wire logic [31:0]  rdata,
    input wire logic         analog_start,
    input wire logic         irq,
    input wire logic         irq_oe
);
    logic cfg_wr;
    assign cfg_wr = bus.wr && (bus.addr == OFS_CONFIG);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
        else $error("read data not zero outside answer cycle");
    a_rdata_width: assert property ($past(bus.rd) |-> rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_unmapped_read: assert property ($past(bus.rd) && $past(bus.addr) == 8'h40 |-> rdata == 32'h0)
        else $error("unmapped read not zero");
    a_oe_follow: assert property (cfg_wr |-> ##2 irq_oe == $past(bus.wdata[1], 2))
        else $error("irq_oe does not follow enable bit");
    a_oe_cause: assert property ($changed(irq_oe) |-> $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("irq_oe changed without config write");
    a_clear_irq: assert property (cfg_wr && bus.wdata[3] |-> ##3 !irq)
        else $error("irq high after clear bit set");
    a_mask_irq: assert property (bus.wr && bus.addr == OFS_MASK && bus.wdata[1:0] == 2'h3
        |-> ##3 !irq)
        else $error("irq high with all sources masked");
    a_start_once: assert property (analog_start |=> !analog_start)
        else $error("analog_start longer than one cycle");
    a_start_cause: assert property (analog_start
        |-> $past(cfg_wr) || $past(cfg_wr, 2) || $past(cfg_wr, 3))
        else $error("analog_start without config write");
    c_start: cover property (analog_start);
    c_irq: cover property ($rose(irq));
    c_full: cover property ($past(bus.rd) && rdata == 32'hff);
endmodule
bind ftm_fan_monitor ftm_checker i_ftm_checker (
    .ref_clk(ref_clk), .nrst(nrst), .tach_input_first(tach_input_first),
    .tach_input_second(tach_input_second), .bus(bus), .rdata(rdata),
    .analog_start(analog_start), .irq(irq), .irq_oe(irq_oe));

//--- sim/ftm_fan_model.sv
// Purpose: One fan tach output, square wave of set half period
// Assumes: Half period in ref_clk cycles; 0 means stopped
// Notes:   A stopped fan sits at the pull-up level
`timescale 1ns/10ps
module ftm_fan_model (
    // Clock
    input  wire logic        ref_clk,
    // Setting
    input  wire logic [15:0] half,
    // Tach output
    output logic             tach
);
    logic [15:0] cnt = 16'h0;
    initial tach = 1'b1;
    always @(posedge ref_clk) begin
        if (half == 16'h0 || cnt + 16'h1 >= half) begin
            cnt <= 16'h0;
            tach <= (half == 16'h0) ? 1'b1 : ~tach;
        end else begin
            cnt <= cnt + 16'h1;
        end
    end
endmodule

//--- sim/tb.sv
// Purpose: Register-level tests of the fan tach period monitor
// Assumes: DIV set to 4, so one count is 4 cycles times divisor
// Notes:   Counts allow one count of gating phase slack
`timescale 1ns/10ps
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end
module tb;
    import ftm_pkg::*;
    logic         ref_clk = 1'b0;
    logic         nrst;
    ftm_bus_req_t bus;
    logic [31:0]  rdata;
    logic [31:0]  rv;
    logic         analog_start;
    logic         irq;
    logic         irq_oe;
    logic         tach_a;
    logic         tach_b;
    logic [15:0]  half_a;
    logic [15:0]  half_b;
    int           fail_count = 0;
    int           n_tests = 0;

    always #5 ref_clk = ~ref_clk;

    ftm_fan_monitor #(.DIV(4)) i_ftm_fan_monitor (
        .ref_clk(ref_clk), .nrst(nrst), .tach_input_first(tach_a),
        .tach_input_second(tach_b), .bus(bus), .rdata(rdata),
        .analog_start(analog_start), .irq(irq), .irq_oe(irq_oe));
    ftm_fan_model fan_first (.ref_clk(ref_clk), .half(half_a), .tach(tach_a));
    ftm_fan_model fan_second (.ref_clk(ref_clk), .half(half_b), .tach(tach_b));

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd_raw(input logic [7:0] a);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        // Read data stands for one cycle only; take it mid-cycle
        @(negedge ref_clk);
        rv = rdata;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        rd_raw(a);
        `CHK(what, exp, rv)
    endtask
    // Gating phase may add or drop one count
    task automatic spd(input logic [7:0] a, input logic [7:0] nom, input string what);
        rd_raw(a);
        if (rv[31:8] == 24'h0 && (rv[7:0] == nom + 8'h1 || rv[7:0] + 8'h1 == nom)) begin
            n_tests++;
        end else begin
            `CHK(what, nom, rv)
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic close_out;
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge ref_clk);
        fail_count++;
        close_out();
    end

    initial begin
        nrst = 1'b0;
        bus = '0;
        half_a = 16'd100;
        half_b = 16'd160;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rd(OFS_VIDDIV, 32'h50, "divisor reset");
        rd(OFS_LIMIT1, 32'hff, "limit1 reset");
        rd(OFS_CHMODE, 32'h0, "chmode reset");
        rd(8'h40, 32'h0, "unmapped read");
        wr(OFS_CONFIG, 32'h3);
        // Wait covers three periods of each fan with margin
        idle(3000);
        spd(OFS_SPEED1, 8'd50, "speed1");
        spd(OFS_SPEED2, 8'd80, "speed2");
        for (int d = 0; d < 4; d++) begin
            wr(OFS_VIDDIV, 32'h40 | (d << DIV1_LSB));
            idle(3500);
            spd(OFS_SPEED1, 8'(100 >> d), "speed1 divisor");
        end
        spd(OFS_SPEED2, 8'd80, "speed2 untouched");
        wr(OFS_VIDDIV, 32'h40);
        half_a <= 16'd1000;
        idle(9000);
        rd(OFS_SPEED1, 32'hff, "speed1 full");
        half_a <= 16'd100;
        wr(OFS_VIDDIV, 32'h50);
        wr(OFS_LIMIT1, 32'h20);
        idle(3500);
        `CHK("irq set", 1'b1, irq)
        `CHK("irq_oe", 1'b1, irq_oe)
        rd(OFS_STATUS, 32'h1, "status");
        rd(OFS_STATUS, 32'h0, "status cleared");
        idle(3500);
        `CHK("irq again", 1'b1, irq)
        wr(OFS_MASK, 32'h3);
        idle(3);
        `CHK("irq masked", 1'b0, irq)
        wr(OFS_MASK, 32'h0);
        wr(OFS_CONFIG, 32'hb);
        idle(3);
        `CHK("irq cleared", 1'b0, irq)
        wr(OFS_CONFIG, 32'h3);
        wr(OFS_LIMIT1, 32'hff);
        idle(3500);
        rd(OFS_STATUS, 32'h0, "status in limit");
        `CHK("irq low", 1'b0, irq)
        wr(OFS_CHMODE, 32'h1);
        // Let a tach_input_first measurement already under way finish at the old speed
        idle(2000);
        half_a <= 16'd50;
        idle(3500);
        spd(OFS_SPEED1, 8'd50, "speed1 analog pin");
        spd(OFS_SPEED2, 8'd80, "speed2 alone");
        close_out();
    end
endmodule
